// ---- inc/scp_pkg.sv ----
// Purpose: Constants for the secure configuration programming block.
// Assumes: APB slave, 32-bit data, one clock.
// Notes: Byte addresses; reserved bits read as zero.
package scp_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_KEY0 = 8'h10;
  localparam logic [7:0] A_KEY3 = 8'h1c;
  localparam logic [7:0] A_PSET = 8'h20;
  localparam logic [7:0] A_PUNL = 8'h24;
  localparam logic [7:0] A_ISTAT = 8'h28;
  localparam logic [7:0] A_IMASK = 8'h2c;
  localparam logic [7:0] A_WIN = 8'h40;
  localparam logic [7:0] A_WIN_END = 8'h7c;
  localparam int C_START = 0;
  localparam int C_ENC = 1;
  localparam int C_REG = 2;
  localparam int C_RELOCK = 4;
  localparam int I_PASS = 0;
  localparam int I_FAIL = 1;
  localparam int I_REFUSE = 2;
  localparam logic [1:0] REG_NONE = 2'h3;
  localparam logic [4:0] DEPTH = 5'h10;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_MED = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_CHECK = 3'b010,
    ST_ERASE = 3'b011,
    ST_PROG = 3'b100
  } scp_state_e;
endpackage : scp_pkg

// ---- core/scp_core.sv ----
// Purpose: Secure programming path: decrypt, authenticate, erase, program.
// Assumes: Stream words synchronous to i_core_clk; last word is the tag.
// Notes: Cipher and tag are a compact keyed stand-in for the real core.
`timescale 1ns/1ps
`default_nettype none
module scp_core (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_fab_clear,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_prog_valid,
  input wire logic [31:0] i_prog_data,
  input wire logic i_prog_last,
  output logic o_prog_ready,
  output logic [2:0] o_region_live,
  output logic o_busy,
  output logic o_auth_pass,
  output logic o_auth_fail,
  output logic o_irq
);
  scp_pkg::scp_state_e state;
  logic [31:0] buf_mem [0:15];
  logic [31:0] nv_mem [0:63];
  logic [31:0] key_mem [0:3];
  logic [31:0] passkey;
  logic pass_set;
  logic key_set;
  logic [2:0] nv_valid;
  logic unlocked;
  logic locked;
  logic [1:0] region;
  logic enc;
  logic [4:0] cnt;
  logic [3:0] wp;
  logic ovf;
  logic [31:0] mac;
  logic [31:0] tag;
  logic [2:0] irq_st;
  logic [2:0] irq_mask;
  logic [2:0] ev;
  logic acc;
  logic wr_fire;
  logic rd_fire;
  logic start;
  logic refuse;
  logic take;
  logic [31:0] ks;
  logic [31:0] plain;
  logic [31:0] next_mac;
  logic [1:0] level;
  logic mapped;
  logic [31:0] rdata;
  logic auth_ok;
  logic prog_done;
  logic start_ok;

  assign locked = pass_set & ~unlocked;
  assign acc = i_psel & i_penable & ~o_pready;
  assign wr_fire = i_psel & i_penable & o_pready & i_pwrite;
  assign rd_fire = i_psel & i_penable & o_pready & ~i_pwrite;
  assign level = !pass_set ? scp_pkg::LVL_NONE :
                 key_set ? scp_pkg::LVL_HIGH : scp_pkg::LVL_MED;
  assign start = wr_fire & (i_paddr == scp_pkg::A_CTRL)
                 & i_pwdata[scp_pkg::C_START];
  // Plaintext is refused while locked: only a stream under the stored
  // key can prove the sender may change the contents.
  assign refuse = (state != scp_pkg::ST_IDLE)
                  | (i_pwdata[scp_pkg::C_REG+:2] == scp_pkg::REG_NONE)
                  | (locked & ~i_pwdata[scp_pkg::C_ENC])
                  | (i_pwdata[scp_pkg::C_ENC] & ~key_set);
  assign take = i_prog_valid & o_prog_ready;
  assign start_ok = start & ~refuse;
  // Tag match over a non-empty stream that fit the staging buffer
  assign auth_ok = (mac == tag) & ~ovf & (cnt != 5'h0);
  assign prog_done = (state == scp_pkg::ST_PROG)
                     & ({1'b0, wp} == cnt - 5'h1);

  // Keystream derived from the stored key; a foreign key yields garbage
  assign ks = enc ? (key_mem[cnt[1:0]] ^ {27'h0, cnt}) : 32'h0;
  assign plain = i_prog_data ^ ks;
  assign next_mac = {mac[30:0], mac[31]} ^ plain
                    ^ (enc ? key_mem[3] : 32'h0);

  always_comb
  begin
    mapped = 1'b1;
    rdata = 32'h0;
    case (i_paddr)
      scp_pkg::A_CTRL: rdata = {27'h0, region, enc, 1'b0};
      scp_pkg::A_STAT: rdata = {24'h0, level, key_set, pass_set, locked,
                                o_auth_fail, o_auth_pass, o_busy};
      scp_pkg::A_ISTAT: rdata = {29'h0, irq_st};
      scp_pkg::A_IMASK: rdata = {29'h0, irq_mask};
      scp_pkg::A_PSET, scp_pkg::A_PUNL: rdata = 32'h0;
      default:
      begin
        if (i_paddr >= scp_pkg::A_KEY0 && i_paddr <= scp_pkg::A_KEY3 &&
            i_paddr[1:0] == 2'h0)
          rdata = 32'h0;
        else if (i_paddr >= scp_pkg::A_WIN && i_paddr <= scp_pkg::A_WIN_END
                 && i_paddr[1:0] == 2'h0)
          rdata = nv_mem[{region, i_paddr[5:2]}];
        else
          mapped = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end
    else
    begin
      o_pready <= acc;
      o_pslverr <= acc & ~mapped;
      if (acc)
        o_prdata <= i_pwrite ? 32'h0 : rdata;
    end
  end

  // Control register holds the target of the next stream
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      region <= 2'h0;
      enc <= 1'b0;
    end
    else if (start_ok)
    begin
      region <= i_pwdata[scp_pkg::C_REG+:2];
      enc <= i_pwdata[scp_pkg::C_ENC];
    end
  end

  // Security settings survive i_reset; only a factory clear blanks them
  always_ff @(posedge i_core_clk)
  begin
    if (i_fab_clear)
    begin
      pass_set <= 1'b0;
      key_set <= 1'b0;
      passkey <= 32'h0;
    end
    else if (wr_fire)
    begin
      if (i_paddr == scp_pkg::A_PSET && !locked)
      begin
        passkey <= i_pwdata;
        pass_set <= 1'b1;
      end
      if (i_paddr == scp_pkg::A_KEY3 && !locked)
        key_set <= 1'b1;
    end
  end

  // Key cells are write-only; no read path reaches them
  always_ff @(posedge i_core_clk)
  begin
    if (wr_fire && !locked && i_paddr >= scp_pkg::A_KEY0 &&
        i_paddr <= scp_pkg::A_KEY3)
      key_mem[i_paddr[3:2]] <= i_pwdata;
  end

  // Unlock lasts until relock, a wrong unlock write or reset
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset | i_fab_clear)
      unlocked <= 1'b0;
    else if (wr_fire && i_paddr == scp_pkg::A_PUNL)
      unlocked <= pass_set & (i_pwdata == passkey);
    else if (wr_fire && i_paddr == scp_pkg::A_CTRL &&
             i_pwdata[scp_pkg::C_RELOCK])
      unlocked <= 1'b0;
  end

  // Stream staging; nothing touches nv_mem until the tag matches
  always_ff @(posedge i_core_clk)
  begin
    if (take && !i_prog_last && cnt < scp_pkg::DEPTH)
      buf_mem[cnt[3:0]] <= plain;
  end

  // Stream control: load, check, then erase and program
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state <= scp_pkg::ST_IDLE;
      cnt <= 5'h0;
      ovf <= 1'b0;
    end
    else
    begin
      case (state)
        scp_pkg::ST_IDLE:
        begin
          if (start_ok)
          begin
            state <= scp_pkg::ST_LOAD;
            cnt <= 5'h0;
            ovf <= 1'b0;
          end
        end
        scp_pkg::ST_LOAD:
        begin
          if (take)
          begin
            if (i_prog_last)
              state <= scp_pkg::ST_CHECK;
            else if (cnt == scp_pkg::DEPTH)
              ovf <= 1'b1;
            else
              cnt <= cnt + 5'h1;
          end
        end
        scp_pkg::ST_CHECK:
        begin
          if (auth_ok)
            state <= scp_pkg::ST_ERASE;
          else
            state <= scp_pkg::ST_IDLE;
        end
        scp_pkg::ST_ERASE:
        begin
          if (wp == 4'hf)
            state <= scp_pkg::ST_PROG;
        end
        scp_pkg::ST_PROG:
        begin
          if (prog_done)
            state <= scp_pkg::ST_IDLE;
        end
        default: state <= scp_pkg::ST_IDLE;
      endcase
    end
  end

  // Running check value and the captured tag
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      mac <= 32'h0;
      tag <= 32'h0;
    end
    else if (state == scp_pkg::ST_IDLE && start_ok)
      mac <= 32'h0;
    else if (state == scp_pkg::ST_LOAD && take)
    begin
      if (i_prog_last)
        tag <= i_prog_data;
      else
        mac <= next_mac;
    end
  end

  // Erase and program share one word pointer
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      wp <= 4'h0;
    else if (state == scp_pkg::ST_CHECK)
      wp <= 4'h0;
    else if (state == scp_pkg::ST_ERASE || state == scp_pkg::ST_PROG)
      wp <= wp + 4'h1;
  end

  // Only the selected region is erased and rewritten
  always_ff @(posedge i_core_clk)
  begin
    if (state == scp_pkg::ST_ERASE)
      nv_mem[{region, wp}] <= 32'h0;
    else if (state == scp_pkg::ST_PROG)
      nv_mem[{region, wp}] <= buf_mem[wp];
  end

  // Region stays live from its cells through resets
  always_ff @(posedge i_core_clk)
  begin
    if (i_fab_clear)
      nv_valid <= 3'h0;
    else if (state == scp_pkg::ST_ERASE)
      nv_valid[region] <= 1'b0;
    else if (prog_done)
      nv_valid[region] <= 1'b1;
  end

  always_comb
  begin
    ev = 3'h0;
    ev[scp_pkg::I_PASS] = prog_done;
    ev[scp_pkg::I_FAIL] = (state == scp_pkg::ST_CHECK) & ~auth_ok;
    ev[scp_pkg::I_REFUSE] = start & refuse;
  end

  // Set wins over the read-clear in the same cycle; only the bits that
  // the read returned are cleared, so a later event is not lost
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      irq_st <= 3'h0;
    else if (rd_fire && i_paddr == scp_pkg::A_ISTAT)
      irq_st <= (irq_st & ~o_prdata[2:0]) | ev;
    else
      irq_st <= irq_st | ev;
  end

  // Mask has the status layout; o_irq follows one cycle late
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      irq_mask <= 3'h0;
    else if (wr_fire && i_paddr == scp_pkg::A_IMASK)
      irq_mask <= i_pwdata[2:0];
  end

  // Result stays until the next accepted start
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_auth_pass <= 1'b0;
      o_auth_fail <= 1'b0;
    end
    else if (start_ok)
    begin
      o_auth_pass <= 1'b0;
      o_auth_fail <= 1'b0;
    end
    else
    begin
      if (ev[scp_pkg::I_PASS])
        o_auth_pass <= 1'b1;
      if (ev[scp_pkg::I_FAIL])
        o_auth_fail <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_irq <= 1'b0;
      o_busy <= 1'b0;
      o_prog_ready <= 1'b0;
      o_region_live <= 3'h0;
    end
    else
    begin
      o_irq <= |(irq_st & irq_mask);
      o_busy <= state != scp_pkg::ST_IDLE;
      o_prog_ready <= (state == scp_pkg::ST_LOAD) & ~(take & i_prog_last)
                      | (state == scp_pkg::ST_IDLE) & start_ok;
      o_region_live <= nv_valid;
    end
  end
endmodule : scp_core
`default_nettype wire

// ---- dv/scp_core_sva.sv ----
// Purpose: Port checker for scp_core.
// Assumes: Bound to scp_core; one clock domain.
// Notes: Status bits inside are judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module scp_core_sva (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_prog_valid,
  input wire logic i_prog_last,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_prog_ready,
  input wire logic [2:0] o_region_live,
  input wire logic o_busy,
  input wire logic o_auth_pass,
  input wire logic o_auth_fail
);
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  chk_apb_wait: assert property (
    i_psel && i_penable && !o_pready |=> o_pready) else $error("no answer");
  chk_ready_pulse: assert property (
    o_pready |=> !o_pready) else $error("ready too long");
  chk_err_pair: assert property (
    o_pslverr |-> o_pready) else $error("lone error");
  chk_one_result: assert property (
    !(o_auth_pass && o_auth_fail)) else $error("pass and fail");
  chk_load_live: assert property (
    o_prog_ready && $past(o_prog_ready) |-> $stable(o_region_live))
    else $error("config changed while loading");
  chk_fail_keep: assert property (
    $rose(o_auth_fail) |-> $stable(o_region_live))
    else $error("config changed on fail");
  chk_pass_live: assert property (
    $rose(o_auth_pass) |=> o_region_live != 3'h0) else $error("no region");
  chk_tag_end: assert property (
    i_prog_valid && i_prog_last && o_prog_ready |=> !o_prog_ready && o_busy)
    else $error("load did not end");
endmodule : scp_core_sva
bind scp_core scp_core_sva u_sva (.i_core_clk(i_core_clk),
  .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_prog_valid(i_prog_valid), .i_prog_last(i_prog_last),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prog_ready(o_prog_ready),
  .o_region_live(o_region_live), .o_busy(o_busy),
  .o_auth_pass(o_auth_pass), .o_auth_fail(o_auth_fail));
`default_nettype wire

// ---- dv/scp_host.sv ----
// Purpose: Programming host model driving the stream port.
// Assumes: Called right after a clock edge; last word is the tag.
// Notes: A gap makes a slow host; idle data shows the inverse value.
`timescale 1ns/1ps
`default_nettype none
module scp_host (
  input wire logic i_clk,
  input wire logic i_ready,
  input wire logic [127:0] i_key,
  output logic o_valid = 1'b0,
  output logic [31:0] o_data = 32'h0,
  output logic o_last = 1'b0
);
  task automatic send(input int n, input logic enc, input int gap);
    logic [31:0] p;
    logic [31:0] m;
    m = 32'h0;
    for (int k = 0; k <= n; k++)
    begin
      p = 32'h5a00_0000 + k;
      o_valid <= 1'b1;
      o_last <= (k == n);
      if (k < n)
      begin
        m = {m[30:0], m[31]} ^ p ^ (enc ? i_key[127:96] : 32'h0);
        o_data <= p ^ (enc ? i_key[32*(k%4)+:32] ^ k : 32'h0);
      end
      else
        o_data <= m;
      @(posedge i_clk);
      while (!i_ready)
        @(posedge i_clk);
      if (gap > 0)
      begin
        o_valid <= 1'b0;
        o_data <= ~o_data;
        repeat (gap) @(posedge i_clk);
      end
    end
    o_valid <= 1'b0;
    o_last <= 1'b0;
    o_data <= ~o_data;
  endtask : send
endmodule : scp_host
`default_nettype wire

// ---- dv/scp_core_tb.sv ----
// Purpose: Self-checking bench for scp_core.
// Assumes: Host model on the stream port; APB master tasks.
// Notes: The interrupt wait is bounded; a watchdog ends any other hang.
`timescale 1ns/1ps
`default_nettype none
module scp_core_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fab = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, pd, rv;
  logic rdy, err, pv, pl, prr, busy, ap, af, irq, ev;
  logic [2:0] live;
  logic [127:0] key = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
  logic [127:0] hkey;
  int n_fail = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  scp_core uut (.i_core_clk(clk), .i_reset(rst), .i_fab_clear(fab),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_prog_valid(pv), .i_prog_data(pd), .i_prog_last(pl),
    .o_prog_ready(prr), .o_region_live(live), .o_busy(busy),
    .o_auth_pass(ap), .o_auth_fail(af), .o_irq(irq));
  scp_host host (.i_clk(clk), .i_ready(prr), .i_key(hkey), .o_valid(pv),
    .o_data(pd), .o_last(pl));
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : ck
  // Entered just after an edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (!rdy)
      @(posedge clk);
    rv = prd;
    ev = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    ck(rv, exp);
  endtask : rd
  // Start, stream, then judge the event bits and the interrupt
  task automatic run(input logic [31:0] c, input int n, input logic [31:0] is);
    int t;
    apb(1'b1, scp_pkg::A_CTRL, c);
    if (is != 32'h4)
      host.send(n, c[1], c[1] ? 0 : 2);
    t = 0;
    while (!irq && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    ck({31'h0, irq}, 32'h1);
    rd(scp_pkg::A_ISTAT, is);
    repeat (2) @(posedge clk);
    ck({31'h0, irq}, 32'h0);
  endtask : run
  task automatic t_plain;
    apb(1'b1, scp_pkg::A_IMASK, 32'h7);
    rd(scp_pkg::A_STAT, 32'h0);
    run(32'h5, 3, 32'h1);
    ck({29'h0, live}, 32'h2);
    ck({30'h0, af, ap}, 32'h1);
    run(32'h1, 0, 32'h2);
    ck({29'h0, live}, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    ck({31'h0, ev}, 32'h1);
  endtask : t_plain
  task automatic t_lock;
    for (int i = 0; i < 4; i++)
      apb(1'b1, scp_pkg::A_KEY0 + 8'(4 * i), key[32*i+:32]);
    rd(scp_pkg::A_KEY0, 32'h0);
    apb(1'b1, scp_pkg::A_PSET, 32'h1234_5678);
    apb(1'b1, scp_pkg::A_CTRL, 32'h10);
    apb(1'b0, scp_pkg::A_STAT, 32'h0);
    ck(rv & 32'hf8, 32'hb8);
    run(32'hb, 5, 32'h1);
    ck({29'h0, live}, 32'h6);
    rd(scp_pkg::A_WIN + 8'h4, 32'h5a00_0001);
    rd(scp_pkg::A_WIN + 8'h14, 32'h0);
  endtask : t_lock
  // Key writes while locked must be lost, so the old key still works
  task automatic t_bad;
    hkey = key ^ 128'h1;
    run(32'h3, 4, 32'h2);
    ck({29'h0, live}, 32'h6);
    hkey = key;
    run(32'h1, 2, 32'h4);
    apb(1'b1, scp_pkg::A_PUNL, 32'h0bad_0bad);
    apb(1'b1, scp_pkg::A_KEY0, 32'h0);
    run(32'h3, 4, 32'h1);
    ck({29'h0, live}, 32'h7);
  endtask : t_bad
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  initial
  begin
    hkey = key;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    fab <= 1'b0;
    @(posedge clk);
    t_plain;
    t_lock;
    t_bad;
    finish_test;
  end
  initial
  begin
    #20000;
    n_fail++;
    finish_test;
  end
endmodule : scp_core_tb
`default_nettype wire
